/* reset_clock_setup.sv */
// device reset, prescaler, channel c clock and test mode logic
// What this block does
// - channel c baud timing comes from its own 16x clock input
// - bus select high makes the reset input active high
// - bus select low makes the reset input active low, same function
// - reset held at least 40 ns resets the channel registers and outputs; bus mode and test mode keep following their pins
// - during reset transmit lines high, receive ignored, outputs at defaults
// - read, write and chip select all low enters factory test mode
// - each channel has its own independent control state
// - baud generator input of every channel but c is prescaled by one or four
// - receiver samples at sixteen times the bit rate
// - prescale pin sampled at reset; modem control bit 7 overrides later
// - bus select high means intel signalling, low motorola
`timescale 1ns/10ps
module reset_clock_setup #(
  parameter int NUM_CH     = reset_clock_setup_pkg::NUM_CHANNELS,
  parameter int FIFO_DEPTH = reset_clock_setup_pkg::FIFO_BYTES
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  input  wire logic              channel_c_clock_in,
  input  wire logic              reset_pin,
  input  wire logic              bus_select_pin,
  input  wire logic              prescale_select_pin,
  input  wire logic              read_strobe_n,
  input  wire logic              write_strobe_n,
  input  wire logic              chip_select_n,
  input  wire logic [NUM_CH-1:0] rx_in,
  input  wire logic [NUM_CH-1:0] prescale_override_wr,
  input  wire logic [NUM_CH-1:0] prescale_override_val,
  output logic [NUM_CH-1:0]      tx_out,
  output logic [NUM_CH-1:0]      channel_reset,
  output logic [NUM_CH-1:0]      sample_tick,
  output logic [NUM_CH-1:0]      rx_sampled,
  output logic [NUM_CH-1:0]      prescale_div4,
  output logic                   intel_mode,
  output logic                   factory_test_mode,
  output logic                   chan_c_rst_sync_b
);
  initial begin
    if (NUM_CH != reset_clock_setup_pkg::NUM_CHANNELS) $error("four channels only");
    if (FIFO_DEPTH != reset_clock_setup_pkg::FIFO_BYTES) $error("fifo depth must be 128");
  end

  typedef struct packed {
    logic [1:0]        rst_meta;
    logic [1:0]        bus_meta;
    logic [1:0]        psel_meta;
    logic [1:0]        rd_meta;
    logic [1:0]        wr_meta;
    logic [1:0]        cs_meta;
    logic [NUM_CH-1:0] rx_meta1;
    logic [NUM_CH-1:0] rx_meta2;
    logic [3:0]        rst_cnt;
    logic              in_reset;
    logic              in_reset_d;
    logic              intel;
    logic              test_mode;
    logic [NUM_CH-1:0] div4;
    logic [NUM_CH-1:0][1:0] pre_cnt;
    logic [NUM_CH-1:0][3:0] samp_cnt;
    logic [NUM_CH-1:0] tick;
    logic [NUM_CH-1:0] tx;
    logic [NUM_CH-1:0] rx_q;
  } top_state_t;

  top_state_t state_reg;
  top_state_t state_next;

  // channel c clock domain edge detect, via two-flop level crossing
  logic       chc_rst_b;
  logic [2:0] chc_toggle_sync;
  logic       chc_toggle;
  logic       chc_rst_src_b;

  // pin reset must also hold channel c, not only power-on reset
  assign chc_rst_src_b = rst_b & ~state_reg.in_reset;

  // reset-release synchroniser for the channel c domain
  reset_sync u_chc_rst (
    .clk        (channel_c_clock_in),
    .rst_b      (chc_rst_src_b),
    .rst_sync_b (chc_rst_b)
  );

  // channel c 16x clock: each rising edge flips a toggle, carried across
  always_ff @(posedge channel_c_clock_in or negedge chc_rst_b) begin
    if (!chc_rst_b) begin
      chc_toggle <= 1'b0;
    end else begin
      chc_toggle <= ~chc_toggle;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      chc_toggle_sync <= 3'h0;
    end else begin
      chc_toggle_sync <= {chc_toggle_sync[1:0], chc_toggle};
    end
  end

  // reset pin polarity follows bus select
  function automatic logic reset_active(input logic pin, input logic intel_sel);
    reset_active = intel_sel ? pin : ~pin;
  endfunction

  logic rst_level;
  logic chc_tick;

  always_comb begin
    state_next = state_reg;
    state_next.rst_meta  = {state_reg.rst_meta[0], reset_pin};
    state_next.bus_meta  = {state_reg.bus_meta[0], bus_select_pin};
    state_next.psel_meta = {state_reg.psel_meta[0], prescale_select_pin};
    state_next.rd_meta   = {state_reg.rd_meta[0], read_strobe_n};
    state_next.wr_meta   = {state_reg.wr_meta[0], write_strobe_n};
    state_next.cs_meta   = {state_reg.cs_meta[0], chip_select_n};
    state_next.rx_meta1  = rx_in;
    state_next.rx_meta2  = state_reg.rx_meta1;
    state_next.intel     = state_reg.bus_meta[1];

    rst_level = reset_active(state_reg.rst_meta[1], state_reg.bus_meta[1]);
    chc_tick  = chc_toggle_sync[2] ^ chc_toggle_sync[1];

    // qualify reset: must stand 40 ns before it takes effect
    if (rst_level) begin
      if (state_reg.rst_cnt < 4'(reset_clock_setup_pkg::RESET_MIN_CYCLES)) begin
        state_next.rst_cnt = state_reg.rst_cnt + 4'h1;
      end
      if (state_reg.rst_cnt >= 4'(reset_clock_setup_pkg::RESET_MIN_CYCLES - 1)) begin
        state_next.in_reset = 1'b1;
      end
    end else begin
      state_next.rst_cnt  = reset_clock_setup_pkg::CNT_ZERO;
      state_next.in_reset = 1'b0;
    end
    state_next.in_reset_d = state_reg.in_reset;

    state_next.test_mode = ~state_reg.rd_meta[1] & ~state_reg.wr_meta[1]
                           & ~state_reg.cs_meta[1];

    for (int ch = 0; ch < NUM_CH; ch++) begin
      if (state_reg.in_reset) begin
        // prescale pin sampled only while reset stands
        state_next.div4[ch]     = ~state_reg.psel_meta[1];
        state_next.pre_cnt[ch]  = reset_clock_setup_pkg::PRESCALE_DIV1;
        state_next.samp_cnt[ch] = reset_clock_setup_pkg::CNT_ZERO;
        state_next.tick[ch]     = 1'b0;
        state_next.tx[ch]       = reset_clock_setup_pkg::TX_IDLE_LEVEL;
        state_next.rx_q[ch]     = 1'b1;
      end else begin
        if (prescale_override_wr[ch]) begin
          state_next.div4[ch] = prescale_override_val[ch];
        end
        state_next.tick[ch] = 1'b0;
        state_next.tx[ch]   = reset_clock_setup_pkg::TX_IDLE_LEVEL;
        if (ch == reset_clock_setup_pkg::CHAN_C) begin
          // channel c input is already the 16x clock
          state_next.tick[ch] = chc_tick;
        end else if (!state_reg.div4[ch] ||
                     state_reg.pre_cnt[ch] == reset_clock_setup_pkg::PRESCALE_DIV4) begin
          state_next.pre_cnt[ch] = reset_clock_setup_pkg::PRESCALE_DIV1;
          state_next.tick[ch]    = 1'b1;
        end else begin
          state_next.pre_cnt[ch] = state_reg.pre_cnt[ch] + 2'h1;
        end
        if (state_reg.tick[ch]) begin
          state_next.samp_cnt[ch] = state_reg.samp_cnt[ch] + 4'h1;
          // mid-bit sample at count 7 of 16
          if (state_reg.samp_cnt[ch] == (reset_clock_setup_pkg::SAMPLE_TERM >> 1)) begin
            state_next.rx_q[ch] = state_reg.rx_meta2[ch];
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg          <= '0;
      state_reg.in_reset <= 1'b1;
      state_reg.tx       <= '1;
      state_reg.rx_q     <= '1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign tx_out            = state_reg.tx;
  assign channel_reset     = {NUM_CH{state_reg.in_reset_d}};
  assign sample_tick       = state_reg.tick;
  assign rx_sampled        = state_reg.rx_q;
  assign prescale_div4     = state_reg.div4;
  assign intel_mode        = state_reg.intel;
  assign factory_test_mode = state_reg.test_mode;
  assign chan_c_rst_sync_b = chc_rst_b;

  a_tx_held_high: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state_reg.in_reset |=> &tx_out)
    else $error("transmit low during reset");

  a_reset_qualify: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $rose(state_reg.in_reset) |-> $past(state_reg.rst_cnt) >= 4'(reset_clock_setup_pkg::RESET_MIN_CYCLES - 1))
    else $error("reset taken before minimum width");

  a_reset_polarity: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_reg.bus_meta[1] && state_reg.rst_meta[1] == 1'b0) |=> state_reg.rst_cnt == 4'h0)
    else $error("intel reset counted while pin low");

  a_reset_polarity_m: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!state_reg.bus_meta[1] && state_reg.rst_meta[1]) |=> state_reg.rst_cnt == 4'h0)
    else $error("motorola reset counted while pin high");

  a_test_mode_entry: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!state_reg.rd_meta[1] && !state_reg.wr_meta[1] && !state_reg.cs_meta[1]) |=> factory_test_mode)
    else $error("test mode not entered");

  a_div1_every_cycle: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!state_reg.in_reset && !state_reg.div4[0] && !prescale_override_wr[0]) [*2] |=> sample_tick[0])
    else $error("divide by one missed a tick");

  a_div4_spacing: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (sample_tick[1] && prescale_div4[1] && !state_reg.in_reset) |=> !sample_tick[1] [*3])
    else $error("divide by four ticks too close");

  a_prescale_strap: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state_reg.in_reset |=> prescale_div4[3] == ~$past(state_reg.psel_meta[1]))
    else $error("prescale strap not captured");

  a_chc_tick_src: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!state_reg.in_reset && chc_tick) |=> sample_tick[reset_clock_setup_pkg::CHAN_C])
    else $error("channel c tick lost");

  a_bus_mode: assert property (@(posedge clk_sys) disable iff (!rst_b)
    intel_mode == $past(state_reg.bus_meta[1]))
    else $error("bus mode mismatch");

  // checks on the reset outputs
  a_rx_held_reset: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state_reg.in_reset |=> &rx_sampled)
    else $error("receive sample not forced high in reset");

  a_tick_in_reset: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state_reg.in_reset |=> sample_tick == '0)
    else $error("sample tick during reset");

  a_chan_reset_on: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state_reg.in_reset |=> &channel_reset)
    else $error("channel reset not raised");

  a_chan_reset_off: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !state_reg.in_reset |=> channel_reset == '0)
    else $error("channel reset not released");

  a_reset_release: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !rst_level |=> !state_reg.in_reset)
    else $error("internal reset outlived the pin");

  a_chc_held: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state_reg.in_reset |-> !chan_c_rst_sync_b)
    else $error("channel c left reset too soon");

  // reset counter follows the selected polarity
  a_intel_counts: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_reg.bus_meta[1] && state_reg.rst_meta[1]
     && state_reg.rst_cnt < 4'(reset_clock_setup_pkg::RESET_MIN_CYCLES))
    |=> state_reg.rst_cnt == $past(state_reg.rst_cnt) + 4'h1)
    else $error("intel reset not counted");

  a_moto_counts: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!state_reg.bus_meta[1] && !state_reg.rst_meta[1]
     && state_reg.rst_cnt < 4'(reset_clock_setup_pkg::RESET_MIN_CYCLES))
    |=> state_reg.rst_cnt == $past(state_reg.rst_cnt) + 4'h1)
    else $error("motorola reset not counted");

  a_test_mode_exit: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_reg.rd_meta[1] || state_reg.wr_meta[1] || state_reg.cs_meta[1]) |=> !factory_test_mode)
    else $error("test mode without all three strobes");

  // override takes effect outside reset only
  a_override_load: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!state_reg.in_reset && prescale_override_wr[0])
    |=> prescale_div4[0] == $past(prescale_override_val[0]))
    else $error("prescale override not loaded");

  a_strap_all: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state_reg.in_reset |=> prescale_div4 == {NUM_CH{~$past(state_reg.psel_meta[1])}})
    else $error("override taken during reset");

  // mid-bit sampling on the 16x tick
  a_rx_mid_sample: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!state_reg.in_reset && state_reg.tick[0]
     && state_reg.samp_cnt[0] == (reset_clock_setup_pkg::SAMPLE_TERM >> 1))
    |=> rx_sampled[0] == $past(state_reg.rx_meta2[0]))
    else $error("mid-bit sample missed");

  a_rx_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!state_reg.in_reset && !state_reg.tick[0]) |=> $stable(rx_sampled[0]))
    else $error("receive sample moved without tick");

  a_samp_count: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!state_reg.in_reset && state_reg.tick[3])
    |=> state_reg.samp_cnt[3] == $past(state_reg.samp_cnt[3]) + 4'h1)
    else $error("sample counter did not advance");
endmodule // reset_clock_setup

/* reset_clock_setup_pkg.sv */
// constants for the quad uart reset, clock and mode-entry block
package reset_clock_setup_pkg;
  localparam int          NUM_CHANNELS      = 4;
  localparam int          CHAN_C            = 2;
  localparam int          FIFO_BYTES        = 128;
  localparam int          SAMPLE_RATE       = 16;
  localparam int          CLK_PERIOD_PS     = 8000;
  localparam int          RESET_MIN_PS      = 40000;
  localparam int          RESET_MIN_CYCLES  = (RESET_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [1:0]  PRESCALE_DIV1     = 2'h0;
  localparam logic [1:0]  PRESCALE_DIV4     = 2'h3;
  localparam logic [3:0]  SAMPLE_TERM       = 4'hF;
  localparam logic [3:0]  CNT_ZERO          = 4'h0;
  localparam logic        TX_IDLE_LEVEL     = 1'b1;
  localparam int          MC_PRESCALE_BIT   = 7;
endpackage

/* reset_sync.sv */
// reset release synchroniser for one channel clock domain
`timescale 1ns/10ps
module reset_sync (
  input  wire logic clk,
  input  wire logic rst_b,
  output logic      rst_sync_b
);
  typedef struct packed {
    logic s1;
    logic s2;
  } sync_state_t;

  sync_state_t state_reg;
  sync_state_t state_next;

  always_comb begin
    state_next    = state_reg;
    state_next.s1 = 1'b1;
    state_next.s2 = state_reg.s1;
  end

  // assert at once, release after two edges
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rst_sync_b = state_reg.s2;

  a_release_delay: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(rst_sync_b) |-> $past(rst_b))
    else $error("reset released too early");
endmodule // reset_sync

/* host_model.sv */
// host side model driving the reset, mode, strap and strobe pins
`timescale 1ns/10ps
module host_model (
  input  wire logic clk_sys,
  output logic      channel_c_clock_in,
  output logic      reset_pin,
  output logic      bus_select_pin,
  output logic      prescale_select_pin,
  output logic      read_strobe_n,
  output logic      write_strobe_n,
  output logic      chip_select_n
);
  initial begin
    channel_c_clock_in = 1'b0;
    reset_pin = 1'b0;
    bus_select_pin = 1'b1;
    prescale_select_pin = 1'b1;
    {read_strobe_n, write_strobe_n, chip_select_n} = 3'h7;
  end
  // free 16x baud clock, unrelated to the system clock
  always #13 channel_c_clock_in = ~channel_c_clock_in;
  // active level follows the bus style; hold given in cycles
  task automatic pulse_reset(input logic intel, input logic strap, input int cycles);
    @(negedge clk_sys);
    bus_select_pin = intel;
    prescale_select_pin = strap;
    reset_pin = intel;
    repeat (cycles) @(negedge clk_sys);
    reset_pin = ~intel;
  endtask
  // all three low only when a scenario asks for it
  task automatic strobes(input logic [2:0] rd_wr_cs);
    @(negedge clk_sys);
    {read_strobe_n, write_strobe_n, chip_select_n} = rd_wr_cs;
  endtask
endmodule // host_model

/* tb.sv */
// self-checking bench for the reset, prescale and test-mode block
`timescale 1ns/10ps
module tb;
  logic       clk_sys = 1'b0;
  logic       rst_b = 1'b0;
  logic [3:0] rx_in = 4'h0;
  logic [3:0] ovr_wr = 4'h0;
  logic [3:0] ovr_val = 4'h0;
  logic       chc_clk, rst_pin, bus_sel, pre_sel, rd_n, wr_n, cs_n;
  logic [3:0] tx_out, chan_rst, tick, rx_smp, div4;
  logic       intel_mode, test_mode, chc_sync_b;
  int         fails = 0;
  int         num_checks = 0;
  int         cyc = 0;
  always #4 clk_sys = ~clk_sys;
  host_model host (.clk_sys(clk_sys), .channel_c_clock_in(chc_clk), .reset_pin(rst_pin), .bus_select_pin(bus_sel),
    .prescale_select_pin(pre_sel), .read_strobe_n(rd_n), .write_strobe_n(wr_n), .chip_select_n(cs_n));
  reset_clock_setup dut (.clk_sys(clk_sys), .rst_b(rst_b), .channel_c_clock_in(chc_clk), .reset_pin(rst_pin),
    .bus_select_pin(bus_sel), .prescale_select_pin(pre_sel), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
    .chip_select_n(cs_n), .rx_in(rx_in), .prescale_override_wr(ovr_wr), .prescale_override_val(ovr_val),
    .tx_out(tx_out), .channel_reset(chan_rst), .sample_tick(tick), .rx_sampled(rx_smp), .prescale_div4(div4),
    .intel_mode(intel_mode), .factory_test_mode(test_mode), .chan_c_rst_sync_b(chc_sync_b));
  task automatic check_bits(input logic [3:0] got, input logic [3:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic count_ticks(input int ch, output logic [3:0] n);
    n = 4'h0;
    repeat (12) begin
      @(negedge clk_sys);
      if (tick[ch] === 1'b1) n++;
    end
  endtask
  task automatic t_power_up;
    check_bits(tx_out, 4'hF, "tx in reset");
    check_bits(rx_smp, 4'hF, "rx in reset");
    @(negedge clk_sys) rst_b = 1'b1;
    wait_cyc(12);
    check_bits(chan_rst, 4'h0, "released");
    check_bits({3'h0, intel_mode}, 4'h1, "intel");
    check_bits(div4, 4'h0, "strap div1");
    check_bits({3'h0, chc_sync_b}, 4'h1, "chc out");
  endtask
  task automatic t_intel_reset;
    logic [3:0] n;
    host.pulse_reset(1'b1, 1'b0, 12);
    check_bits(chan_rst, 4'hF, "pin reset");
    check_bits(tx_out, 4'hF, "tx held");
    check_bits(rx_smp, 4'hF, "rx ignored");
    check_bits({3'h0, chc_sync_b}, 4'h0, "chc held");
    rx_in = 4'hF;
    wait_cyc(12);
    check_bits(chan_rst, 4'h0, "pin release");
    check_bits({3'h0, chc_sync_b}, 4'h1, "chc released");
    check_bits(div4, 4'hF, "strap div4");
    count_ticks(0, n);
    check_bits(n, 4'h3, "div4 ticks");
  endtask
  task automatic t_short_pulse;
    logic [3:0] seen;
    seen = 4'h0;
    host.pulse_reset(1'b1, 1'b1, 3);
    repeat (12) begin
      @(negedge clk_sys);
      seen = seen | chan_rst;
    end
    check_bits(seen, 4'h0, "short pulse");
    check_bits(div4, 4'hF, "strap unsampled");
  endtask
  task automatic t_override;
    logic [3:0] n;
    ovr_wr = 4'h5;
    @(negedge clk_sys) ovr_wr = 4'h0;
    wait_cyc(2);
    check_bits(div4, 4'hA, "override");
    count_ticks(0, n);
    check_bits(n, 4'hC, "div1 ticks");
    count_ticks(1, n);
    check_bits(n, 4'h3, "other kept");
    count_ticks(2, n);
    check_bits({3'h0, n >= 4'h3 && n <= 4'h4}, 4'h1, "chc ticks");
    rx_in = 4'hE;
    wait_cyc(20);
    check_bits(rx_smp, 4'hE, "rx mid sample");
  endtask
  task automatic t_test_mode;
    for (int c = 7; c >= 0; c--) begin
      host.strobes(3'(c));
      wait_cyc(4);
      check_bits({3'h0, test_mode}, {3'h0, c == 0}, "test mode");
    end
    host.strobes(3'h7);
    wait_cyc(4);
    check_bits({3'h0, test_mode}, 4'h0, "test exit");
  endtask
  task automatic t_motorola;
    host.pulse_reset(1'b0, 1'b1, 12);
    check_bits(chan_rst, 4'hF, "low reset");
    check_bits({3'h0, intel_mode}, 4'h0, "motorola");
    wait_cyc(12);
    check_bits(chan_rst, 4'h0, "low release");
    check_bits(div4, 4'h0, "strap div1");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      tally_and_finish();
    end
  end
  initial begin
    wait_cyc(12);
    t_power_up();
    t_intel_reset();
    t_short_pulse();
    t_override();
    t_test_mode();
    t_motorola();
    tally_and_finish();
  end
endmodule // tb
